// ### src/pto_consts.svh
`ifndef PTO_CONSTS_SVH
`define PTO_CONSTS_SVH

// Command codes
`define PTO_CMD_LIMIT        8'h62
`define PTO_CMD_ACTION       8'h63

// Reset values
`define PTO_LIMIT_RESET      16'h0064
`define PTO_ACTION_RESET     8'h80

// Fields of the action byte
`define PTO_RESP_MSB         7
`define PTO_RESP_LSB         6
`define PTO_RETRY_MSB        5
`define PTO_RETRY_LSB        3
`define PTO_DELAY_MSB        2
`define PTO_DELAY_LSB        0

// Retry codes
`define PTO_RETRY_NONE       3'h0
`define PTO_RETRY_FOREVER    3'h7

// Timing
`define PTO_CLOCK_HZ         50000000
`define PTO_MS_PER_S         1000
`define PTO_MS_CYCLES        (`PTO_CLOCK_HZ / `PTO_MS_PER_S)

`endif

// ### src/pto_ms_tick.sv
// Purpose: one-cycle enable pulse once per millisecond
// Assumes: CLOCK at 50 MHz
// Notes:   divider restarts when clr is high so a timed phase starts aligned
`include "pto_consts.svh"
module pto_ms_tick #(
    parameter int MS_CYCLES = `PTO_MS_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clr,
    output logic      tick
);
    import pto_pkg::*;

    logic [31:0] count;
    wire         at_end = (count == 32'(MS_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst || clr || at_end) begin
            count <= 32'h0;
        end else begin
            count <= count + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clr) begin
            tick <= 1'b0;
        end else begin
            tick <= at_end;
        end
    end
endmodule // pto_ms_tick

// ### src/pto_pkg.sv
// Purpose: types shared by the power-up timeout supervisor
// Assumes: constants come from pto_consts.svh
// Notes:   none
package pto_pkg;

    typedef enum logic [1:0] {
        PTO_RESP_IGNORE,
        PTO_RESP_DELAYED,
        PTO_RESP_DISABLE_RETRY,
        PTO_RESP_LATCH
    } pto_resp_t;

    typedef enum logic [2:0] {
        PTO_OFF,
        PTO_RAMP,
        PTO_RUN,
        PTO_GRACE,
        PTO_BACKOFF,
        PTO_LATCHED
    } pto_state_t;

endpackage

// ### src/pto_supervisor.sv
// Purpose: power-up timeout supervision with programmable fault response
// Assumes: command port carries already-decoded bus transfers
// Notes:   all times are counted in 1 ms steps from pto_ms_tick
// Behaviour
// - Timeout fault when ramp exceeds ms limit
// - Zero limit disables the timeout
// - Response 00 keeps running normally
// - Response 01 waits delay, then retries
// - Response 10 disables output then retries
// - Response 11 latches off until cleared
// - Retry code 000 never restarts
// - Codes 001-110 retry that many times
// - Restart spacing is unit times two to the power of the delay field
// - Only some response encodings need support
// - Limit by word, action by byte
// - Retry code 111 retries without limit
// - Delay field is power-of-two multiplier
// - Time unit shared with output voltage faults
`include "pto_consts.svh"
module pto_supervisor #(
    parameter int MS_CYCLES = `PTO_MS_CYCLES
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic        CMD_WORD,
    input  wire logic        CMD_WRITE,
    input  wire logic        CMD_READ,
    input  wire logic [15:0] CMD_WDATA,
    output logic      [15:0] CMD_RDATA,
    output logic             CMD_ACK,
    output logic             CMD_ERROR,
    input  wire logic        ON_CMD,
    input  wire logic        RAMP_START,
    input  wire logic        VOUT_ABOVE_UV,
    input  wire logic [7:0]  VOUT_FAULT_UNIT_MS,
    input  wire logic        CLEAR_FAULTS,
    input  wire logic        CLEAR_TIMEOUT_BIT,
    output logic             OUTPUT_ENABLE,
    output logic             RESTART,
    output logic             TIMEOUT_FAULT,
    output pto_pkg::pto_state_t STATE
);
    import pto_pkg::*;

    logic [15:0] power_up_time_limit;
    logic [7:0]  power_up_timeout_action;
    pto_state_t  state;
    logic [15:0] ms_count;
    logic [22:0] wait_count;
    logic [2:0]  tries_left;
    logic        ms_tick;

    // Delay in ms: unit times 2^field; a zero unit acts as 1 ms
    function automatic logic [22:0] delay_ms(input logic [7:0] unit, input logic [2:0] field);
        logic [22:0] base;
        base = (unit == 8'h00) ? 23'h1 : {15'h0, unit};
        return base << field;
    endfunction

    // Register access
    wire hit_limit  = (CMD_CODE == `PTO_CMD_LIMIT);
    wire hit_action = (CMD_CODE == `PTO_CMD_ACTION);
    wire size_ok    = (hit_limit && CMD_WORD) || (hit_action && !CMD_WORD);
    wire access     = CMD_WRITE || CMD_READ;
    wire wr_limit   = CMD_WRITE && hit_limit && CMD_WORD;
    wire wr_action  = CMD_WRITE && hit_action && !CMD_WORD;
    wire [15:0] rd_value = hit_limit ? power_up_time_limit
                                     : {8'h00, power_up_timeout_action};

    // Action fields
    wire [1:0]  resp_code  = power_up_timeout_action[`PTO_RESP_MSB:`PTO_RESP_LSB];
    wire [2:0]  retry_code = power_up_timeout_action[`PTO_RETRY_MSB:`PTO_RETRY_LSB];
    wire [2:0]  delay_code = power_up_timeout_action[`PTO_DELAY_MSB:`PTO_DELAY_LSB];
    wire [22:0] delay_len  = delay_ms(VOUT_FAULT_UNIT_MS, delay_code);
    pto_resp_t  resp;
    assign resp = pto_resp_t'(resp_code);

    // Timeout detection during ramp
    wire limit_on     = (power_up_time_limit != 16'h0000);
    wire timeout_hit  = (state == PTO_RAMP) && limit_on && !VOUT_ABOVE_UV
                        && (ms_count >= power_up_time_limit);
    wire wait_done    = ms_tick && (wait_count + 23'h1 >= delay_len);
    wire retries_out  = (retry_code == `PTO_RETRY_NONE)
                        || ((retry_code != `PTO_RETRY_FOREVER)
                            && (tries_left == 3'h0));
    wire clear_req    = CLEAR_FAULTS || CLEAR_TIMEOUT_BIT;
    wire restart_now  = (state == PTO_BACKOFF) && wait_done && ON_CMD;
    wire start_ramp   = ((state == PTO_OFF) && ON_CMD && RAMP_START) || restart_now;
    wire phase_start  = start_ramp || (timeout_hit && resp != PTO_RESP_IGNORE);

    pto_ms_tick #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .clk  (CLOCK),
        .rst  (RST),
        .clr  (phase_start),
        .tick (ms_tick)
    );

    // Where a fault that needs action goes after the output is dropped
    pto_state_t after_disable;
    assign after_disable = retries_out ? PTO_LATCHED : PTO_BACKOFF;

    pto_state_t next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            PTO_OFF: begin
                if (ON_CMD && RAMP_START) begin
                    next_state = PTO_RAMP;
                end
            end
            PTO_RAMP: begin
                if (VOUT_ABOVE_UV) begin
                    next_state = PTO_RUN;
                end else if (timeout_hit) begin
                    // Every encoding is honoured, so nothing is left unsupported
                    unique case (resp)
                        PTO_RESP_IGNORE:        next_state = PTO_RUN;
                        PTO_RESP_DELAYED:       next_state = PTO_GRACE;
                        PTO_RESP_DISABLE_RETRY: next_state = after_disable;
                        PTO_RESP_LATCH:         next_state = PTO_LATCHED;
                    endcase
                end
            end
            PTO_RUN: begin
                next_state = PTO_RUN;
            end
            PTO_GRACE: begin
                if (VOUT_ABOVE_UV) begin
                    next_state = PTO_RUN;
                end else if (wait_done) begin
                    next_state = after_disable;
                end
            end
            PTO_BACKOFF: begin
                if (restart_now) begin
                    next_state = PTO_RAMP;
                end
            end
            PTO_LATCHED: begin
                if (clear_req) begin
                    next_state = PTO_OFF;
                end
            end
            // Two state codes are unused; fall back to off
            default: next_state = PTO_OFF;
        endcase
        // Off command ends every phase, including endless retry
        if (!ON_CMD) begin
            next_state = PTO_OFF;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= PTO_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            power_up_time_limit     <= `PTO_LIMIT_RESET;
            power_up_timeout_action <= `PTO_ACTION_RESET;
        end else begin
            if (wr_limit) power_up_time_limit <= CMD_WDATA;
            if (wr_action) power_up_timeout_action <= CMD_WDATA[7:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            CMD_RDATA <= 16'h0000;
            CMD_ACK   <= 1'b0;
            CMD_ERROR <= 1'b0;
        end else begin
            CMD_ACK   <= access;
            CMD_ERROR <= access && !size_ok;
            if (CMD_READ) CMD_RDATA <= size_ok ? rd_value : 16'h0000;
        end
    end

    // Ramp timer in ms, restarted at each ramp start
    always_ff @(posedge CLOCK) begin
        if (RST || start_ramp) begin
            ms_count <= 16'h0000;
        end else if (state == PTO_RAMP && ms_tick && ms_count != 16'hffff) begin
            ms_count <= ms_count + 16'h0001;
        end
    end

    // Grace and back-off timer
    always_ff @(posedge CLOCK) begin
        if (RST || phase_start || (state == PTO_GRACE && next_state != PTO_GRACE)) begin
            wait_count <= 23'h0;
        end else if (ms_tick) begin
            wait_count <= wait_count + 23'h1;
        end
    end

    // Retry budget loaded on the first ramp, spent on each restart
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tries_left <= 3'h0;
        end else if (state == PTO_OFF && start_ramp) begin
            tries_left <= retry_code;
        end else if (restart_now && tries_left != 3'h0) begin
            tries_left <= tries_left - 3'h1;
        end
    end

    // Status flag: a new timeout beats a clear in the same cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            TIMEOUT_FAULT <= 1'b0;
        end else if (timeout_hit) begin
            TIMEOUT_FAULT <= 1'b1;
        end else if (clear_req) begin
            TIMEOUT_FAULT <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            OUTPUT_ENABLE <= 1'b0;
            RESTART       <= 1'b0;
        end else begin
            OUTPUT_ENABLE <= (next_state == PTO_RAMP) || (next_state == PTO_RUN)
                             || (next_state == PTO_GRACE);
            RESTART       <= restart_now && (next_state == PTO_RAMP);
        end
    end

    assign STATE = state;
endmodule // pto_supervisor

// ### tb/pto_stage_model.sv
// Purpose: power stage: output rises while enabled
// Assumes: rise takes RISE cycles
// Notes:   good low gives a stage that never reaches UV level
module pto_stage_model #(
    parameter int RISE = 3
) (
    input  wire logic clk,
    input  wire logic en,
    input  wire logic good,
    output logic      above
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    always @(posedge clk) cnt <= en ? cnt + 1 : 0;
    assign above = en && good && cnt >= RISE;
endmodule // pto_stage_model

// ### tb/pto_supervisor_props.sv
// Purpose: port assertions for pto_supervisor
// Assumes: one clock, RST synchronous active high
// Notes:   bound after endmodule
module pto_supervisor_props (
    input wire logic                CLOCK,
    input wire logic                RST,
    input wire logic [7:0]          CMD_CODE,
    input wire logic                CMD_WORD,
    input wire logic                CMD_WRITE,
    input wire logic                CMD_READ,
    input wire logic                CMD_ACK,
    input wire logic                CMD_ERROR,
    input wire logic                ON_CMD,
    input wire logic                RAMP_START,
    input wire logic                VOUT_ABOVE_UV,
    input wire logic                CLEAR_FAULTS,
    input wire logic                CLEAR_TIMEOUT_BIT,
    input wire logic                OUTPUT_ENABLE,
    input wire logic                RESTART,
    input wire logic                TIMEOUT_FAULT,
    input wire pto_pkg::pto_state_t STATE
);
    timeunit 1ns;
    timeprecision 1ns;
    import pto_pkg::*;
    wire strobe = CMD_WRITE | CMD_READ;
    wire hold = ON_CMD & ~CLEAR_FAULTS & ~CLEAR_TIMEOUT_BIT;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    a_ack_follows: assert property (strobe |=> CMD_ACK)
        else $error("no ack after strobe");
    a_size_refused:
        assert property (CMD_WRITE && CMD_CODE == 8'h62 && !CMD_WORD |=> CMD_ERROR)
        else $error("byte write to limit accepted");
    a_ramp_enables:
        assert property (STATE == PTO_OFF && ON_CMD && RAMP_START |=> OUTPUT_ENABLE)
        else $error("ramp start not taken");
    a_cmd_off: assert property (!ON_CMD |=> STATE == PTO_OFF)
        else $error("off command ignored");
    a_enable_state:
        assert property (OUTPUT_ENABLE == (STATE inside {PTO_RAMP, PTO_RUN, PTO_GRACE}))
        else $error("enable disagrees with state");
    a_fault_sticky: assert property (TIMEOUT_FAULT && hold |=> TIMEOUT_FAULT)
        else $error("flag dropped without clear");
    a_latch_holds: assert property (STATE == PTO_LATCHED && hold |=> STATE == PTO_LATCHED)
        else $error("left latch without clear");
    a_fault_ramp:
        assert property ($rose(TIMEOUT_FAULT) |-> $past(STATE) == PTO_RAMP && !$past(VOUT_ABOVE_UV))
        else $error("fault outside failing ramp");
    a_restart_order:
        assert property (RESTART |-> $past(STATE) == PTO_BACKOFF && STATE == PTO_RAMP)
        else $error("restart not from backoff");
    cover property (STATE == PTO_LATCHED);
    cover property (RESTART);
    cover property (STATE == PTO_GRACE);
endmodule // pto_supervisor_props

bind pto_supervisor pto_supervisor_props i_pto_supervisor_props (.CLOCK, .RST, .CMD_CODE,
    .CMD_WORD, .CMD_WRITE, .CMD_READ, .CMD_ACK, .CMD_ERROR, .ON_CMD, .RAMP_START,
    .VOUT_ABOVE_UV, .CLEAR_FAULTS, .CLEAR_TIMEOUT_BIT, .OUTPUT_ENABLE, .RESTART,
    .TIMEOUT_FAULT, .STATE);

// ### tb/testbench.sv
// Purpose: self-checking bench for pto_supervisor
// Assumes: ms shortened to 4 cycles
// Notes:   inputs change on the falling edge
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pto_pkg::*;
    logic        CLOCK = 1'b0, RST = 1'b1, CMD_WORD = 1'b0, CMD_WRITE = 1'b0, CMD_READ = 1'b0;
    logic        ON_CMD = 1'b0, RAMP_START = 1'b0, CLEAR_FAULTS = 1'b0, CLEAR_TIMEOUT_BIT = 1'b0;
    logic        good = 1'b0, VOUT_ABOVE_UV, CMD_ACK, CMD_ERROR, OUTPUT_ENABLE, RESTART;
    logic        TIMEOUT_FAULT;
    logic [7:0]  CMD_CODE = 8'h00, VOUT_FAULT_UNIT_MS = 8'h01;
    logic [15:0] CMD_WDATA = 16'h0000, CMD_RDATA;
    pto_state_t  STATE;
    int          err_count = 0, checks_done = 0;
    initial forever #10 CLOCK = ~CLOCK;
    pto_supervisor #(.MS_CYCLES(4)) i_pto_supervisor (.CLOCK, .RST, .CMD_CODE, .CMD_WORD,
        .CMD_WRITE, .CMD_READ, .CMD_WDATA, .CMD_RDATA, .CMD_ACK, .CMD_ERROR, .ON_CMD,
        .RAMP_START, .VOUT_ABOVE_UV, .VOUT_FAULT_UNIT_MS, .CLEAR_FAULTS, .CLEAR_TIMEOUT_BIT,
        .OUTPUT_ENABLE, .RESTART, .TIMEOUT_FAULT, .STATE);
    pto_stage_model i_pto_stage_model (.clk(CLOCK), .en(OUTPUT_ENABLE), .good,
        .above(VOUT_ABOVE_UV));
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Idle edge first so a strobe is never lowered and raised in one step
    task automatic xfer(logic wr, logic [7:0] code, logic word, logic [15:0] d, logic err);
        @(negedge CLOCK);
        {CMD_WRITE, CMD_READ, CMD_CODE, CMD_WORD, CMD_WDATA} = {wr, !wr, code, word, d};
        @(negedge CLOCK);
        {CMD_WRITE, CMD_READ} = 2'h0;
        check("ack", {15'h0, CMD_ACK}, 16'h1);
        check("error", {15'h0, CMD_ERROR}, {15'h0, err});
        if (!wr) check("rdata", CMD_RDATA, d);
    endtask
    task automatic wait_st(pto_state_t st, int n);
        repeat (n) begin
            if (STATE === st) return;
            @(negedge CLOCK);
        end
        err_count++;
        $display("wrong value state exp %s seen %s", st.name(), STATE.name());
        wrap_up();
    endtask
    task automatic pwr(logic [7:0] act, logic [15:0] lim, logic ok);
        ON_CMD = 1'b0;
        good = ok;
        xfer(1'b1, 8'h63, 1'b0, {8'h00, act}, 1'b0);
        xfer(1'b1, 8'h62, 1'b1, lim, 1'b0);
        {CLEAR_FAULTS, ON_CMD} = 2'h3;
        @(negedge CLOCK);
        {CLEAR_FAULTS, RAMP_START} = 2'h1;
        @(negedge CLOCK);
        RAMP_START = 1'b0;
        check("enable", {15'h0, OUTPUT_ENABLE}, 16'h1);
    endtask
    task automatic s_regs();
        xfer(1'b0, 8'h62, 1'b1, 16'h0064, 1'b0);
        xfer(1'b0, 8'h63, 1'b0, 16'h0080, 1'b0);
        xfer(1'b1, 8'h62, 1'b1, 16'ha5c3, 1'b0);
        xfer(1'b1, 8'h62, 1'b0, 16'h0011, 1'b1);
        xfer(1'b0, 8'h62, 1'b1, 16'ha5c3, 1'b0);
        xfer(1'b0, 8'h63, 1'b1, 16'h0000, 1'b1);
        xfer(1'b0, 8'h64, 1'b1, 16'h0000, 1'b1);
    endtask
    task automatic s_runs(logic [7:0] act, logic [15:0] lim, logic ok, pto_state_t st);
        pwr(act, lim, ok);
        repeat (40) @(negedge CLOCK);
        check("state", STATE, st);
        check("flag", {15'h0, TIMEOUT_FAULT}, {15'h0, act == 8'h00});
    endtask
    task automatic s_delayed();
        pwr(8'h41, 16'h0001, 1'b0);
        wait_st(PTO_GRACE, 12);
        check("grace enable", {15'h0, OUTPUT_ENABLE}, 16'h1);
        wait_st(PTO_LATCHED, 20);
    endtask
    task automatic s_retry(logic [7:0] act, logic [7:0] unit);
        int n = 0;
        int len = 0;
        VOUT_FAULT_UNIT_MS = unit;
        pwr(act, 16'h0001, 1'b0);
        repeat (200) begin
            @(negedge CLOCK);
            n += RESTART;
            len += (STATE == PTO_BACKOFF);
        end
        if (act[5:3] == 3'h2) begin
            check("restarts", n[15:0], 16'h2);
            check("backoff", 16'(len >= 32 && len <= 36), 16'h1);
            check("state", STATE, PTO_LATCHED);
        end else begin
            check("endless", 16'(n > 10), 16'h1);
            ON_CMD = 1'b0;
            repeat (2) @(negedge CLOCK);
            check("state", STATE, PTO_OFF);
        end
        VOUT_FAULT_UNIT_MS = 8'h01;
    endtask
    task automatic s_latch(logic [7:0] act);
        pwr(act, 16'h0001, 1'b0);
        wait_st(PTO_LATCHED, 12);
        repeat (30) @(negedge CLOCK);
        check("state", STATE, PTO_LATCHED);
        CLEAR_TIMEOUT_BIT = 1'b1;
        @(negedge CLOCK);
        CLEAR_TIMEOUT_BIT = 1'b0;
        @(negedge CLOCK);
        check("state", STATE, PTO_OFF);
        check("flag", {15'h0, TIMEOUT_FAULT}, 16'h0);
    endtask
    // Output comes up during the grace time, so the unit keeps running
    task automatic s_recover();
        pwr(8'h42, 16'h0001, 1'b0);
        wait_st(PTO_GRACE, 12);
        good = 1'b1;
        repeat (2) @(negedge CLOCK);
        check("state", STATE, PTO_RUN);
        check("flag", {15'h0, TIMEOUT_FAULT}, 16'h1);
    endtask
    // Reset in mid-run drops the flag and restores both registers
    task automatic s_reset();
        pwr(8'h00, 16'h0001, 1'b0);
        wait_st(PTO_RUN, 12);
        check("flag", {15'h0, TIMEOUT_FAULT}, 16'h1);
        RST = 1'b1;
        repeat (2) @(negedge CLOCK);
        RST = 1'b0;
        @(negedge CLOCK);
        check("state", STATE, PTO_OFF);
        check("enable", {15'h0, OUTPUT_ENABLE}, 16'h0);
        check("flag", {15'h0, TIMEOUT_FAULT}, 16'h0);
        xfer(1'b0, 8'h62, 1'b1, 16'h0064, 1'b0);
        xfer(1'b0, 8'h63, 1'b0, 16'h0080, 1'b0);
    endtask
    initial begin
        repeat (10) @(negedge CLOCK);
        RST = 1'b0;
        s_regs();
        s_runs(8'h80, 16'h0000, 1'b0, PTO_RAMP);
        s_runs(8'h80, 16'h0002, 1'b1, PTO_RUN);
        s_runs(8'h00, 16'h0001, 1'b0, PTO_RUN);
        s_delayed();
        s_retry(8'h91, 8'h02);
        s_retry(8'hb8, 8'h01);
        s_latch(8'hc0);
        s_latch(8'h80);
        s_recover();
        s_reset();
        wrap_up();
    end
endmodule // testbench
